// ==== rtl/spipin_core.sv ====
// spi pin interface: master/slave shifter, pin muxing with gpio, rx fifo
`timescale 1ns/10ps
module spipin_core
   import spipin_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic master_mode_i,
   input wire logic [3:0] gpio_func_i,
   input wire logic [3:0] gpio_dir_i,
   input wire logic [3:0] gpio_out_i,
   output logic [3:0] gpio_in_o,
   input wire logic tx_valid_i,
   input wire logic [SPIPIN_DATA_W-1:0] tx_data_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output logic [SPIPIN_DATA_W-1:0] rx_data_o,
   input wire logic rx_ready_i,
   output logic mode_fault_o,
   output logic busy_o,
   input wire logic [3:0] pin_i,
   output logic [3:0] pin_o,
   output logic [3:0] pin_oe_b_o
);
   spipin_stream_if rx_s ();
   spipin_stream_if rx_m ();

   spipin_fifo #(.WIDTH(SPIPIN_DATA_W), .DEPTH(SPIPIN_FIFO_DEPTH)) u_rx_fifo (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .wr(rx_s.snk),
      .rd(rx_m.src)
   );
   assign rx_valid_o = rx_m.valid;
   assign rx_data_o = rx_m.data;
   assign rx_m.ready = rx_ready_i;

   // two-stage synchronisers for every pin
   // reset to idle levels (select high, clock low) so no false clock edge follows reset
   localparam logic [3:0] PIN_IDLE = 4'h8;
   logic [3:0] sync1_q, sync2_q, prev_q;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= PIN_IDLE;
         sync2_q <= PIN_IDLE;
         prev_q <= PIN_IDLE;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // function/mode registered every clock; spi from reset until software moves them
   logic [3:0] func_q, func_d, dir_q, dir_d, gout_q, gout_d;
   logic mst_q, mst_d;
   logic [3:0] gin_q, gin_d;
   always_comb begin
      func_d = gpio_func_i;
      dir_d = gpio_dir_i;
      gout_d = gpio_out_i;
      mst_d = master_mode_i;
      gin_d = sync2_q;
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         func_q <= SPIPIN_FUNC_RST;
         dir_q <= SPIPIN_DIR_RST;
         gout_q <= SPIPIN_OUT_RST;
         mst_q <= 1'b0;
         gin_q <= 4'h0;
      end else begin
         func_q <= func_d;
         dir_q <= dir_d;
         gout_q <= gout_d;
         mst_q <= mst_d;
         gin_q <= gin_d;
      end
   end
   assign gpio_in_o = gin_q;

   logic sel_active, ext_rise, ext_fall, sel_pin, sclk_pin;
   assign sel_pin = sync2_q[SPIPIN_IDX_SEL];
   assign sclk_pin = sync2_q[SPIPIN_IDX_SCLK];
   assign sel_active = !func_q[SPIPIN_IDX_SEL] && !sel_pin;
   assign ext_rise = sclk_pin && !prev_q[SPIPIN_IDX_SCLK];
   assign ext_fall = !sclk_pin && prev_q[SPIPIN_IDX_SCLK];

   // shared shifter for both roles (mode 0: sample on rise, change on fall)
   spipin_mst_type st_q, st_d;
   logic [SPIPIN_DATA_W-1:0] sh_q, sh_d, rxw_q, rxw_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] div_q, div_d;
   logic sclk_q, sclk_d, mosi_q, mosi_d, miso_q, miso_d;
   logic fault_q, fault_d, rxv_q, rxv_d, loaded_q, loaded_d;
   logic in_bit;

   assign in_bit = mst_q ? sync2_q[SPIPIN_IDX_MISO] : sync2_q[SPIPIN_IDX_MOSI];
   assign tx_ready_o = (st_q == SPIPIN_IDLE) && !loaded_q && !fault_q;
   assign rx_s.valid = rxv_q;
   assign rx_s.data = rxw_q;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bit_d = bit_q;
      div_d = div_q;
      sclk_d = sclk_q;
      mosi_d = mosi_q;
      miso_d = miso_q;
      fault_d = fault_q;
      loaded_d = loaded_q;
      rxw_d = rxw_q;
      rxv_d = rxv_q && !rx_s.ready;
      if (tx_valid_i && tx_ready_o) begin
         sh_d = tx_data_i;
         loaded_d = 1'b1;
         bit_d = SPIPIN_BIT_ZERO;
         // first bit shown before the first sampling edge
         mosi_d = tx_data_i[SPIPIN_DATA_W-1];
         miso_d = tx_data_i[SPIPIN_DATA_W-1];
      end
      if (mst_q) begin
         if (sel_active) begin
            fault_d = 1'b1;
            st_d = SPIPIN_IDLE;
            sclk_d = 1'b0;
            loaded_d = 1'b0;
         end else begin
            case (st_q)
               SPIPIN_IDLE: begin
                  if (loaded_q && !rxv_q) begin
                     st_d = SPIPIN_LEAD;
                     div_d = SPIPIN_HALF_CYC;
                  end
               end
               SPIPIN_LEAD: begin
                  // mosi stood for a half period before this rise
                  div_d = div_q - 8'h01;
                  if (div_q == 8'h01) begin
                     sclk_d = 1'b1;
                     sh_d = {sh_q[SPIPIN_DATA_W-2:0], in_bit};
                     div_d = SPIPIN_HALF_CYC;
                     st_d = SPIPIN_TRAIL;
                  end
               end
               SPIPIN_TRAIL: begin
                  div_d = div_q - 8'h01;
                  if (div_q == 8'h01) begin
                     sclk_d = 1'b0;
                     div_d = SPIPIN_HALF_CYC;
                     mosi_d = sh_q[SPIPIN_DATA_W-1];
                     if (bit_q == SPIPIN_LAST_BIT) begin
                        rxw_d = sh_q;
                        rxv_d = 1'b1;
                        loaded_d = 1'b0;
                        st_d = SPIPIN_IDLE;
                     end else begin
                        bit_d = bit_q + 4'h1;
                        st_d = SPIPIN_LEAD;
                     end
                  end
               end
               default: st_d = SPIPIN_IDLE;
            endcase
         end
      end else begin
         st_d = SPIPIN_IDLE;
         sclk_d = 1'b0;
         fault_d = 1'b0;
         if (!sel_active) begin
            bit_d = SPIPIN_BIT_ZERO;
         end else if (ext_rise) begin
            sh_d = {sh_q[SPIPIN_DATA_W-2:0], in_bit};
         end else if (ext_fall) begin
            miso_d = sh_q[SPIPIN_DATA_W-1];
            if (bit_q == SPIPIN_LAST_BIT) begin
               bit_d = SPIPIN_BIT_ZERO;
               rxw_d = sh_q;
               rxv_d = 1'b1; // waits if fifo full; next word overwrites it, master cannot stall
               loaded_d = 1'b0;
            end else begin
               bit_d = bit_q + 4'h1;
            end
         end
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= SPIPIN_IDLE;
         sh_q <= '0;
         bit_q <= SPIPIN_BIT_ZERO;
         div_q <= 8'h00;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         miso_q <= 1'b0;
         fault_q <= 1'b0;
         loaded_q <= 1'b0;
         rxw_q <= '0;
         rxv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         div_q <= div_d;
         sclk_q <= sclk_d;
         mosi_q <= mosi_d;
         miso_q <= miso_d;
         fault_q <= fault_d;
         loaded_q <= loaded_d;
         rxw_q <= rxw_d;
         rxv_q <= rxv_d;
      end
   end
   assign mode_fault_o = fault_q;
   assign busy_o = (st_q != SPIPIN_IDLE);

   // pin muxing; oe is active low
   logic [3:0] spi_oe, spi_out;
   always_comb begin
      spi_oe = 4'h0;
      spi_out = 4'h0;
      spi_oe[SPIPIN_IDX_SCLK] = mst_q;
      spi_out[SPIPIN_IDX_SCLK] = sclk_q;
      spi_oe[SPIPIN_IDX_MOSI] = mst_q;
      spi_out[SPIPIN_IDX_MOSI] = mosi_q;
      spi_oe[SPIPIN_IDX_MISO] = !mst_q && sel_active;
      spi_out[SPIPIN_IDX_MISO] = miso_q;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (func_q[i]) begin
            pin_oe_b_o[i] = !dir_q[i];
            pin_o[i] = gout_q[i];
         end else begin
            pin_oe_b_o[i] = !spi_oe[i];
            pin_o[i] = spi_out[i];
         end
      end
   end
endmodule

// ==== rtl/spipin_fifo.sv ====
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module spipin_fifo
   import spipin_pkg::*;
#(
   parameter int unsigned WIDTH = SPIPIN_DATA_W,
   parameter int unsigned DEPTH = SPIPIN_FIFO_DEPTH
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   spipin_stream_if.snk wr,
   spipin_stream_if.src rd
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;
   assign wr.ready = (cnt_q != DEPTH[AW:0]);
   assign rd.valid = (cnt_q != '0);
   assign rd.data = mem_q[rp_q];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;
   always_comb begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end
   // storage carries no reset, only written on push
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wp_q] <= wr.data;
      end
   end
endmodule

// ==== rtl/spipin_pkg.sv ====
// shared constants and types for the spi pin interface
package spipin_pkg;
   localparam int unsigned SPIPIN_DATA_W = 8;
   localparam int unsigned SPIPIN_FIFO_DEPTH = 16;
   localparam int unsigned SPIPIN_CLK_MHZ = 100;
   // serial clock half period in ns when master
   localparam int unsigned SPIPIN_HALF_NS = 80;
   localparam int unsigned SPIPIN_HALF_CYC_RAW = (SPIPIN_HALF_NS * SPIPIN_CLK_MHZ) / 1000;
   localparam logic [7:0] SPIPIN_HALF_CYC =
      (SPIPIN_HALF_CYC_RAW < 1) ? 8'h01 : SPIPIN_HALF_CYC_RAW[7:0];
   localparam logic [3:0] SPIPIN_LAST_BIT = 4'h7;
   localparam logic [3:0] SPIPIN_BIT_ZERO = 4'h0;
   // pin index within the shared group
   localparam int unsigned SPIPIN_IDX_SCLK = 0;
   localparam int unsigned SPIPIN_IDX_MOSI = 1;
   localparam int unsigned SPIPIN_IDX_MISO = 2;
   localparam int unsigned SPIPIN_IDX_SEL = 3;
   localparam logic [3:0] SPIPIN_FUNC_RST = 4'h0;
   localparam logic [3:0] SPIPIN_DIR_RST = 4'h0;
   localparam logic [3:0] SPIPIN_OUT_RST = 4'h0;
   typedef enum logic [1:0] {
      SPIPIN_IDLE,
      SPIPIN_LEAD,
      SPIPIN_TRAIL
   } spipin_mst_type;
endpackage

// ==== rtl/spipin_stream_if.sv ====
// valid/ready stream carrier between the pin block and its fifo
`timescale 1ns/10ps
interface spipin_stream_if;
   import spipin_pkg::*;
   logic valid;
   logic ready;
   logic [SPIPIN_DATA_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== sim/spipin_core_assertions.sv ====
// port checker for the spi pin block
`timescale 1ns/10ps
module spipin_core_assertions
   import spipin_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic master_mode_i,
   input wire logic [3:0] gpio_func_i,
   input wire logic [3:0] gpio_dir_i,
   input wire logic [3:0] gpio_out_i,
   input wire logic mode_fault_o,
   input wire logic [3:0] pin_i,
   input wire logic [3:0] pin_o,
   input wire logic [3:0] pin_oe_b_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_mst;
      (master_mode_i && !mode_fault_o && gpio_func_i == 4'h0)[*4];
   endsequence
   sequence s_slv;
      (!master_mode_i && gpio_func_i == 4'h0)[*4];
   endsequence
   a_reset_pins_spi: assert property ($rose(rst_b_i) |-> pin_oe_b_o == 4'hf)
      else $error("pin driven after reset");
   a_master_pin_dir: assert property (s_mst |-> pin_oe_b_o[2:0] == 3'h4)
      else $error("master pin directions wrong");
   a_slave_pin_dir: assert property (s_slv |-> pin_oe_b_o[1:0] == 2'h3)
      else $error("slave drives mosi or sclk");
   // select passes a synchroniser first, hence the long run
   a_miso_release: assert property ((!master_mode_i && !gpio_func_i[2] && pin_i[3])[*8]
      |-> pin_oe_b_o[2]) else $error("deselected slave drives miso");
   a_fault_on_select: assert property ((master_mode_i && !gpio_func_i[3] && !pin_i[3])[*8]
      |-> ##[0:4] mode_fault_o) else $error("no fault on select low");
   a_sclk_high_time: assert property (master_mode_i && $rose(pin_o[0])
      |-> pin_o[0][*8]) else $error("sclk high phase not 8 cycles");
   a_mosi_half_lead: assert property (master_mode_i && $rose(pin_o[0])
      |-> pin_o[1] == $past(pin_o[1], 7) ##1 ($stable(pin_o[1]))[*7])
      else $error("mosi not held around sampling edge");
   a_gpio_pin_drv: assert property (($stable(gpio_func_i) && $stable(gpio_dir_i)
      && $stable(gpio_out_i))[*3] |-> (gpio_func_i & ~gpio_dir_i & ~pin_oe_b_o) == 4'h0
      && (gpio_func_i & gpio_dir_i & (pin_oe_b_o | (pin_o ^ gpio_out_i))) == 4'h0)
      else $error("gpio pin drive wrong");
endmodule
bind spipin_core spipin_core_assertions u_chk (.core_clk_i, .rst_b_i, .master_mode_i,
   .gpio_func_i, .gpio_dir_i, .gpio_out_i, .mode_fault_o, .pin_i, .pin_o, .pin_oe_b_o);

// ==== sim/spipin_core_bench.sv ====
// self-checking bench for the spi pin block
`timescale 1ns/10ps
module spipin_core_bench;
   import spipin_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic master = 1'b0;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic [3:0] func = 4'h0;
   logic [3:0] dir = 4'h0;
   logic [3:0] gout = 4'h0;
   logic [7:0] tx_data = 8'h00;
   logic tx_ready, rx_valid, fault, busy, f_sclk, f_mosi, f_miso, f_sel_b;
   logic [7:0] rx_data, got, r;
   logic [3:0] gin, pin_o, oe_b, lvl;
   int fails = 0;
   int tests_run = 0;
   assign lvl = (oe_b & {f_sel_b, f_miso, f_mosi, f_sclk}) | (~oe_b & pin_o);
   spipin_core u_spipin_core (.core_clk_i(clk), .rst_b_i(rst_b), .master_mode_i(master),
      .gpio_func_i(func), .gpio_dir_i(dir), .gpio_out_i(gout), .gpio_in_o(gin),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready),
      .mode_fault_o(fault), .busy_o(busy), .pin_i(lvl), .pin_o(pin_o), .pin_oe_b_o(oe_b));
   spipin_far_end u_spipin_far_end (.sclk_i(lvl[0]), .mosi_i(lvl[1]), .miso_i(lvl[2]),
      .miso_o(f_miso), .sclk_o(f_sclk), .mosi_o(f_mosi), .sel_b_o(f_sel_b), .got_o(got));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic t_master();
      int n;
      master = 1'b1;
      u_spipin_far_end.arm(8'h3c);
      tick(2);
      tx_data = 8'ha5;
      tx_valid = 1'b1;
      tick(1);
      tx_valid = 1'b0;
      tick(1);
      chk("busy", {7'h0, busy}, 8'h01);
      for (n = 0; n < 600 && rx_valid !== 1'b1; n++) begin
         tick(1);
      end
      if (n == 600) begin
         chk("rx wait", 8'h01, 8'h00);
         results();
      end
      chk("idle", {7'h0, busy}, 8'h00);
      chk("master rx", rx_data, 8'h3c);
      chk("far got", got, 8'ha5);
      $display("t_master done");
   endtask
   task automatic t_slave();
      master = 1'b0;
      rx_ready = 1'b1;
      tick(2);
      rx_ready = 1'b0;
      tx_data = 8'h96;
      tx_valid = 1'b1;
      tick(1);
      tx_valid = 1'b0;
      chk("miso oe_b", {7'h0, oe_b[2]}, 8'h01);
      u_spipin_far_end.xfer(8'hff, 1'b1, r);
      chk("deselected rx", {7'h0, rx_valid}, 8'h00);
      for (int i = 0; i < 17; i++) begin
         u_spipin_far_end.xfer(8'h40 + 8'(i), 1'b0, r);
         if (i == 0) chk("slave tx", r, 8'h96);
      end
      tick(8);
      // the word held while the fifo was full lands after the first pop
      for (int i = 0; i < 17; i++) begin
         chk("fifo word", rx_data, 8'h40 + 8'(i));
         rx_ready = 1'b1;
         tick(1);
         rx_ready = 1'b0;
      end
      chk("fifo empty", {7'h0, rx_valid}, 8'h00);
      $display("t_slave done");
   endtask
   task automatic t_fault();
      master = 1'b1;
      tick(2);
      u_spipin_far_end.xfer(8'h00, 1'b0, r);
      chk("fault", {7'h0, fault}, 8'h01);
      chk("tx refused", {7'h0, tx_ready}, 8'h00);
      master = 1'b0;
      tick(3);
      chk("fault clear", {7'h0, fault}, 8'h00);
      $display("t_fault done");
   endtask
   task automatic t_gpio();
      func = 4'hf;
      dir = 4'h5;
      gout = 4'h1;
      tick(6);
      chk("gpio oe_b", {4'h0, oe_b}, 8'h0a);
      chk("gpio out", {4'h0, pin_o & 4'h5}, 8'h01);
      chk("gpio in", {4'h0, gin & 4'hd}, 8'h09);
      $display("t_gpio done");
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (12) @(posedge clk);
      #1;
      chk("reset oe_b", {4'h0, oe_b}, 8'h0f);
      rst_b = 1'b1;
      t_master();
      t_slave();
      t_fault();
      t_gpio();
      results();
   end
endmodule

// ==== sim/spipin_far_end.sv ====
// far end model: slave for the block as master, master for the block as slave
`timescale 1ns/10ps
module spipin_far_end (
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   output logic miso_o,
   output logic sclk_o = 1'b0,
   output logic mosi_o = 1'b0,
   output logic sel_b_o = 1'b1,
   output logic [7:0] got_o
);
   logic [7:0] sh_q;
   assign miso_o = sh_q[7];
   // refill with inverse so a released line never shows a held bit
   always @(negedge sclk_i) sh_q <= {sh_q[6:0], ~sh_q[0]};
   always @(posedge sclk_i) got_o <= {got_o[6:0], mosi_i};
   task automatic arm(input logic [7:0] v);
      sh_q = v;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic sel_b, output logic [7:0] rx);
      rx = 8'h00;
      sel_b_o = sel_b;
      for (int i = 7; i >= 0; i--) begin
         mosi_o = tx[i];
         #80;
         sclk_o = 1'b1;
         rx = {rx[6:0], miso_i};
         #80;
         sclk_o = 1'b0;
      end
      #80;
      sel_b_o = 1'b1;
      mosi_o = ~mosi_o;
      #200;
   endtask
endmodule
